/* include/cbf_pkg.sv */
package cbf_pkg;
  // Bus and datapath widths
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 8;
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 4;
  localparam int STREAM_W   = 24;

  // Mode setup pattern: key on the high lane, mode bits on the low lane
  localparam logic [7:0] SETUP_KEY   = 8'h5a;
  localparam int         MODE_BE_BIT = 0;
  localparam int         MODE_BIG_BIT = 1;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADR_CHIP_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_ATTACH    = 8'h02;
  localparam logic [ADDR_W-1:0] ADR_AREA_CLR  = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_WR_SPACE  = 8'h06;
  localparam logic [ADDR_W-1:0] ADR_RD_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_FIFO_WORD = 8'h0a;
  localparam logic [ADDR_W-1:0] ADR_BYTE_WR   = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_BYTE_RD   = 8'h0e;
  localparam logic [ADDR_W-1:0] ADR_RAM_PORT  = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_RAM_PTR   = 8'h12;
  localparam logic [ADDR_W-1:0] ADR_STREAM_HI = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_STREAM_LO = 8'h16;

  // Field positions
  localparam int ATTACH_WR_BIT = 0;
  localparam int ATTACH_RD_BIT = 1;
  localparam int RD_VALID_BIT  = 15;
  localparam int READY_BIT     = 4;

  // Reset values
  localparam logic [DATA_W-1:0]   DATA_RESET   = 16'h0000;
  localparam logic [STREAM_W-1:0] STREAM_RESET = 24'h00_0000;
  localparam logic [BYTE_W-1:0]   BYTE_ZERO    = 8'h00;

  typedef enum logic [4:0] {
    ST_UNINIT      = 5'b00001,
    ST_SETUP_GAP   = 5'b00010,
    ST_CONFIRM     = 5'b00100,
    ST_CONFIRM_GAP = 5'b01000,
    ST_READY       = 5'b10000
  } cbf_state_t;
endpackage

/* rtl/cbf_byte_fifo.sv */
module cbf_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic                       clock_en,
  input  wire logic                       flush,
  input  wire logic [WIDTH-1:0]           in_data,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      fill
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CW    = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // Full and empty come from the count, so back-pressure is exact
  // Handshakes are offered only while enabled: a frozen buffer must
  // never let the far side believe that a byte moved
  assign in_ready  = clock_en && count_reg != CW'(DEPTH);
  assign out_valid = clock_en && count_reg != '0;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign fill      = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers and count; flush empties the buffer in one cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clock_en) begin
      if (flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push) begin
          wr_ptr_reg <= PTR_W'(wr_ptr_reg + 1'b1);
        end
        if (pop) begin
          rd_ptr_reg <= PTR_W'(rd_ptr_reg + 1'b1);
        end
        if (push && !pop) begin
          count_reg <= CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
          count_reg <= CW'(count_reg - 1'b1);
        end
      end
    end
  end

  // Storage needs no reset; the count guards stale entries
  always_ff @(posedge clock) begin
    if (clock_en && push && !flush) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

/* rtl/cbf_cpu_port.sv */
module cbf_cpu_port
  import cbf_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic                         clock_en,
  input  wire logic                         chip_select_n,
  input  wire logic                         read_strobe_n,
  input  wire logic                         low_byte_write_strobe_n,
  input  wire logic                         high_byte_write_strobe_n,
  input  wire logic                         upper_byte_enable_n,
  input  wire logic                         lower_byte_enable_n,
  input  wire logic [cbf_pkg::ADDR_W-1:0]   address,
  input  wire logic [cbf_pkg::DATA_W-1:0]   data_in,
  output logic [cbf_pkg::DATA_W-1:0]        data_out,
  output logic                              data_oe_n,
  output logic                              interface_ready,
  output logic [cbf_pkg::BYTE_W-1:0]        tx_data,
  output logic                              tx_valid,
  input  wire logic                         tx_ready,
  input  wire logic [cbf_pkg::BYTE_W-1:0]   rx_data,
  input  wire logic                         rx_valid,
  output logic                              rx_ready,
  output logic [cbf_pkg::DATA_W-1:0]        ram_write_data,
  output logic [1:0]                        ram_write_lanes,
  output logic                              ram_write_strobe
);
  import cbf_pkg::*;

  cbf_state_t          state_reg;
  logic                be_mode_reg;
  logic                big_endian_reg;
  logic                wr_act_prev_reg;
  logic                rd_act_prev_reg;
  logic                wr_attach_reg;
  logic                rd_attach_reg;
  logic                wr_boundary_reg;
  logic                rd_boundary_reg;
  logic                pend_reg;
  logic [BYTE_W-1:0]   pend_data_reg;
  logic                rd_second_reg;
  logic                rd_valid_reg;
  logic [CNT_W-1:0]    rd_count_reg;
  logic [STREAM_W-1:0] stream_cnt_reg;
  logic [DATA_W-1:0]   snap_reg;
  logic [DATA_W-1:0]   ram_ptr_reg;
  logic [DATA_W-1:0]   data_out_reg;
  logic                data_oe_n_reg;
  logic                wr_act;
  logic                rd_act;
  logic                wr_start;
  logic                rd_start;
  logic                lane_hi;
  logic                lane_lo;
  logic                lane_first;
  logic                lane_second;
  logic [BYTE_W-1:0]   byte_first;
  logic [BYTE_W-1:0]   byte_second;
  logic                word_wr;
  logic                wpush;
  logic [BYTE_W-1:0]   wdata;
  logic                pend_set;
  logic                tx_in_ready;
  logic [CNT_W-1:0]    tx_fill;
  logic [CNT_W-1:0]    wr_space;
  logic                wr_accept;
  logic                rpop;
  logic                rx_out_valid;
  logic [BYTE_W-1:0]   rx_head;
  logic [CNT_W-1:0]    rx_fill;
  logic                attach_wr;
  logic                detach_rd;
  logic                area_clr;
  logic                is_ready;

  assign is_ready = state_reg[READY_BIT];

  // Lane decode per bus mode; both modes share the one read strobe
  assign lane_hi = be_mode_reg ? !upper_byte_enable_n
                               : !high_byte_write_strobe_n;
  assign lane_lo = be_mode_reg ? !lower_byte_enable_n
                               : !low_byte_write_strobe_n;
  assign wr_act  = !chip_select_n && (be_mode_reg ?
                   !low_byte_write_strobe_n :
                   (!low_byte_write_strobe_n || !high_byte_write_strobe_n));
  assign rd_act  = !chip_select_n && !read_strobe_n;
  // Each access acts once, on its first sampled cycle
  assign wr_start = is_ready && wr_act && !wr_act_prev_reg;
  assign rd_start = is_ready && rd_act && !rd_act_prev_reg;

  // Stream order: big-endian puts the earlier byte on the high lane
  assign lane_first  = big_endian_reg ? lane_hi : lane_lo;
  assign lane_second = big_endian_reg ? lane_lo : lane_hi;
  assign byte_first  = big_endian_reg ? data_in[15:8] : data_in[7:0];
  assign byte_second = big_endian_reg ? data_in[7:0] : data_in[15:8];

  assign word_wr   = wr_start && wr_attach_reg && address == ADR_FIFO_WORD;
  assign attach_wr = wr_start && address == ADR_ATTACH;
  assign detach_rd = attach_wr && rd_attach_reg && !data_in[ATTACH_RD_BIT];
  assign area_clr  = wr_start && address == ADR_AREA_CLR;
  assign wr_space  = CNT_W'(FIFO_DEPTH) - tx_fill;
  assign wr_accept = wpush && tx_in_ready;

  // Mode setup walk; mode bits are captured with the setup write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg      <= ST_UNINIT;
      be_mode_reg    <= 1'b0;
      big_endian_reg <= 1'b0;
    end else if (clock_en) begin
      case (state_reg)
        ST_UNINIT: begin
          if (!chip_select_n && !low_byte_write_strobe_n &&
              data_in[15:8] == SETUP_KEY) begin
            state_reg      <= ST_SETUP_GAP;
            be_mode_reg    <= data_in[MODE_BE_BIT];
            big_endian_reg <= data_in[MODE_BIG_BIT];
          end
        end
        ST_SETUP_GAP: begin
          if (chip_select_n) state_reg <= ST_CONFIRM;
        end
        ST_CONFIRM: begin
          if (!chip_select_n) state_reg <= ST_CONFIRM_GAP;
        end
        ST_CONFIRM_GAP: begin
          if (chip_select_n) state_reg <= ST_READY;
        end
        ST_READY: state_reg <= ST_READY;
        default:  state_reg <= ST_UNINIT;
      endcase
    end
  end

  // Access edge history
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_act_prev_reg <= 1'b0;
      rd_act_prev_reg <= 1'b0;
    end else if (clock_en) begin
      wr_act_prev_reg <= wr_act;
      rd_act_prev_reg <= rd_act;
    end
  end

  // Attach bits are taken from the bus on the internal clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_attach_reg <= 1'b0;
      rd_attach_reg <= 1'b0;
    end else if (clock_en && attach_wr) begin
      wr_attach_reg <= data_in[ATTACH_WR_BIT];
      rd_attach_reg <= data_in[ATTACH_RD_BIT];
    end
  end

  // Write byte selection; a pending second byte always goes first
  always_comb begin
    wpush    = 1'b0;
    wdata    = BYTE_ZERO;
    pend_set = 1'b0;
    if (pend_reg) begin
      wpush = 1'b1;
      wdata = pend_data_reg;
    end else if (word_wr) begin
      if (wr_boundary_reg) begin
        if (lane_second) begin
          wpush = 1'b1;
          wdata = byte_second;
        end
      end else if (lane_first) begin
        wpush    = 1'b1;
        wdata    = byte_first;
        pend_set = lane_second && wr_space > CNT_W'(1);
      end
    end else if (wr_start && wr_attach_reg && address == ADR_BYTE_WR) begin
      wpush = 1'b1;
      wdata = data_in[7:0];
    end
  end
  // A first-lane-only write over a boundary falls through above

  // Second byte of a word write lands one cycle after the first
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= BYTE_ZERO;
    end else if (clock_en) begin
      pend_reg      <= pend_set && wr_accept;
      pend_data_reg <= byte_second;
    end
  end

  // Boundary tracks byte parity, so 4-byte rows act like 2-byte ones
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_boundary_reg <= 1'b0;
    end else if (clock_en) begin
      if (area_clr) begin
        wr_boundary_reg <= 1'b0;
      end else if (wr_accept) begin
        wr_boundary_reg <= !wr_boundary_reg;
      end
    end
  end

  // Bytes sent toward the link; a wide counter that must read stable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stream_cnt_reg <= STREAM_RESET;
    end else if (clock_en && tx_valid && tx_ready) begin
      stream_cnt_reg <= STREAM_W'(stream_cnt_reg + 1'b1);
    end
  end

  // Top-byte read freezes the lower word against carry mid-access
  always_ff @(posedge clock) begin
    if (!resetn) begin
      snap_reg <= DATA_RESET;
    end else if (clock_en && rd_start && address == ADR_STREAM_HI) begin
      snap_reg <= stream_cnt_reg[15:0];
    end
  end

  // Direct RAM port: pointer steps by bytes written, no space check
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ram_ptr_reg      <= DATA_RESET;
      ram_write_data   <= DATA_RESET;
      ram_write_lanes  <= 2'b00;
      ram_write_strobe <= 1'b0;
    end else if (clock_en) begin
      ram_write_strobe <= 1'b0;
      if (wr_start && address == ADR_RAM_PTR) begin
        ram_ptr_reg <= data_in;
      end else if (wr_start && address == ADR_RAM_PORT) begin
        ram_write_data   <= data_in;
        ram_write_lanes  <= {lane_hi, lane_lo};
        ram_write_strobe <= 1'b1;
        ram_ptr_reg      <= DATA_W'(ram_ptr_reg + DATA_W'(lane_hi)
                                    + DATA_W'(lane_lo));
      end
    end
  end

  // Read pops: one on the access edge, one more for a full word
  always_comb begin
    rpop = 1'b0;
    if (rd_second_reg) begin
      rpop = rx_out_valid;
    end else if (rd_start && rd_attach_reg &&
                 (address == ADR_FIFO_WORD || address == ADR_BYTE_RD)) begin
      rpop = rx_out_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_second_reg <= 1'b0;
    end else if (clock_en) begin
      rd_second_reg <= rd_start && rd_attach_reg &&
                       address == ADR_FIFO_WORD && !rd_boundary_reg &&
                       rx_fill > CNT_W'(1);
    end
  end

  // Detach drops the odd byte state; clear beats a pop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_boundary_reg <= 1'b0;
    end else if (clock_en) begin
      if (detach_rd || area_clr) begin
        rd_boundary_reg <= 1'b0;
      end else if (rpop) begin
        rd_boundary_reg <= !rd_boundary_reg;
      end
    end
  end

  // Ready count becomes valid one cycle after attach, then tracks fill
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_valid_reg <= 1'b0;
      rd_count_reg <= '0;
    end else if (clock_en) begin
      rd_valid_reg <= rd_attach_reg;
      rd_count_reg <= rd_attach_reg ? rx_fill : '0;
    end
  end

  // Read data; the unused lane of a partial word reads as zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      data_out_reg <= DATA_RESET;
    end else if (clock_en) begin
      if (rd_second_reg) begin
        if (big_endian_reg) data_out_reg[7:0] <= rx_head;
        else data_out_reg[15:8] <= rx_head;
      end else if (rd_start) begin
        data_out_reg <= DATA_RESET;
        case (address)
          ADR_CHIP_CFG: begin
            data_out_reg[MODE_BE_BIT]  <= be_mode_reg;
            data_out_reg[MODE_BIG_BIT] <= big_endian_reg;
          end
          ADR_ATTACH: begin
            data_out_reg[ATTACH_WR_BIT] <= wr_attach_reg;
            data_out_reg[ATTACH_RD_BIT] <= rd_attach_reg;
          end
          ADR_WR_SPACE:  data_out_reg[CNT_W-1:0] <= wr_space;
          ADR_RD_COUNT: begin
            data_out_reg[CNT_W-1:0]    <= rd_count_reg;
            data_out_reg[RD_VALID_BIT] <= rd_valid_reg;
          end
          ADR_FIFO_WORD: begin
            if (rpop && (rd_boundary_reg == big_endian_reg)) begin
              data_out_reg[7:0] <= rx_head;
            end else if (rpop) begin
              data_out_reg[15:8] <= rx_head;
            end
          end
          ADR_BYTE_RD: if (rpop) data_out_reg[7:0] <= rx_head;
          ADR_RAM_PTR:   data_out_reg <= ram_ptr_reg;
          ADR_STREAM_HI: data_out_reg[7:0] <= stream_cnt_reg[23:16];
          ADR_STREAM_LO: data_out_reg <= snap_reg;
          default:       data_out_reg <= DATA_RESET;
        endcase
      end
    end
  end

  // Enable follows select and read strobe by one sampling cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      data_oe_n_reg <= 1'b1;
    end else if (clock_en) begin
      data_oe_n_reg <= !(is_ready && rd_act);
    end
  end

  assign data_out        = data_out_reg;
  assign data_oe_n       = data_oe_n_reg;
  assign interface_ready = state_reg[READY_BIT];

  cbf_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .clock_en  (clock_en),
    .flush     (area_clr),
    .in_data   (wdata),
    .in_valid  (wpush),
    .in_ready  (tx_in_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .fill      (tx_fill)
  );

  cbf_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .clock_en  (clock_en),
    .flush     (area_clr),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (rx_head),
    .out_valid (rx_out_valid),
    .out_ready (rpop && clock_en),
    .fill      (rx_fill)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_UNINIT_LOCKED: assert property (
    !is_ready |-> !wpush && !rpop && !ram_write_strobe)
    else $error("access acted before mode setup");
  AST_READY_AFTER_CONFIRM: assert property (
    $rose(is_ready) |-> $past(state_reg) == ST_CONFIRM_GAP
                        && $past(chip_select_n))
    else $error("ready without confirmation");
  AST_OE_QUALIFIED: assert property (
    $past(clock_en) && !data_oe_n |->
      $past(!chip_select_n && !read_strobe_n))
    else $error("bus driven outside a read");
  AST_SNAPSHOT_HELD: assert property (
    clock_en && rd_start && address == ADR_STREAM_HI |=>
      snap_reg == $past(stream_cnt_reg[15:0]))
    else $error("lower counter bytes not held");
  AST_BOUNDARY_WORD_LOW: assert property (
    !pend_reg && word_wr && wr_boundary_reg && lane_second |->
      wpush && wdata == byte_second && !pend_set)
    else $error("word over boundary not low only");
  AST_HIGH_ONLY_IGNORED: assert property (
    !pend_reg && word_wr && wr_boundary_reg && !lane_second |-> !wpush)
    else $error("first-lane write over boundary stored");
  AST_LOW_ONLY_IGNORED: assert property (
    !pend_reg && word_wr && !wr_boundary_reg && !lane_first |-> !wpush)
    else $error("second-lane write without boundary stored");
  AST_ONE_FREE_HIGH: assert property (
    !pend_reg && word_wr && !wr_boundary_reg && lane_first && lane_second
      && wr_space == CNT_W'(1) |-> wpush && !pend_set)
    else $error("one free byte took two");
  AST_DETACH_CLEARS: assert property (
    clock_en && detach_rd |=> !rd_boundary_reg && !rd_second_reg)
    else $error("detach kept read boundary");
  AST_BOUNDARY_READ_ONE: assert property (
    clock_en && rd_start && rd_attach_reg && address == ADR_FIFO_WORD
      && rd_boundary_reg |=> !rd_second_reg)
    else $error("boundary word read popped two bytes");
endmodule

/* test/cbf_far_end.sv */
module cbf_far_end (
  input  wire logic       clock,
  input  wire logic       stall,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic [7:0] src [$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // Sink takes bytes whenever the bench does not stall it
  assign tx_ready = !stall;
  // Handshakes complete on the rising edge
  always @(posedge clock) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (rx_valid && rx_ready) void'(src.pop_front());
  end
  // Idle data is inverted so a stale byte can never pass for a new one
  always @(negedge clock) begin
    rx_valid <= src.size() > 0;
    rx_data  <= (src.size() > 0) ? src[0] : ~rx_data;
  end
endmodule

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbf_pkg::*;
  logic        clock = 1'b0;
  logic        resetn, chip_select_n, read_strobe_n, stall;
  logic        low_byte_write_strobe_n, high_byte_write_strobe_n;
  logic [7:0]  address, tx_data, rx_data;
  logic [15:0] data_in, data_out, q;
  logic        data_oe_n, interface_ready, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, clock_en, ram_write_strobe;
  logic        upper_byte_enable_n, lower_byte_enable_n;
  logic [15:0] ram_write_data;
  logic [1:0]  ram_write_lanes;
  int          n_ram = 0;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;

  cbf_cpu_port u_dut (
    .clock, .resetn, .clock_en, .chip_select_n, .read_strobe_n,
    .low_byte_write_strobe_n, .high_byte_write_strobe_n,
    .upper_byte_enable_n, .lower_byte_enable_n,
    .address, .data_in, .data_out, .data_oe_n, .interface_ready,
    .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .ram_write_data, .ram_write_lanes, .ram_write_strobe
  );
  cbf_far_end u_far (
    .clock, .stall, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_ready
  );

  always #5 clock = ~clock;

  // Direct RAM strobe is a one-cycle pulse; count every one seen
  always @(posedge clock) if (ram_write_strobe) n_ram++;

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access held over four samples, long enough for both read lanes
  task automatic bus(input bit wr, input logic [7:0] a,
                     input logic [15:0] d, input logic [1:0] ln);
    @(negedge clock);
    address = a;
    data_in = d;
    chip_select_n = 1'b0;
    if (wr) {high_byte_write_strobe_n, low_byte_write_strobe_n} = ~ln;
    else read_strobe_n = 1'b0;
    repeat (4) @(negedge clock);
    q = data_out;
    if (!wr) chk({15'h0000, data_oe_n}, 16'h0000);
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    {high_byte_write_strobe_n, low_byte_write_strobe_n} = 2'b11;
    repeat (2) @(negedge clock);
    if (!wr) chk({15'h0000, data_oe_n}, 16'h0001);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 2'b00);
    chk(q, exp);
  endtask

  // Wrong key and an early attach write must both be ignored
  task automatic t_refuse();
    bus(1'b1, ADR_CHIP_CFG, 16'h3302, 2'b01);
    bus(1'b1, ADR_ATTACH, 16'h0003, 2'b11);
    chk({15'h0000, interface_ready}, 16'h0000);
  endtask

  // Strobe mode, big-endian: setup, gap, confirmation, gap
  task automatic t_setup();
    bus(1'b1, ADR_CHIP_CFG, 16'h5a02, 2'b01);
    chk({15'h0000, interface_ready}, 16'h0000);
    bus(1'b1, ADR_CHIP_CFG, 16'h5a02, 2'b01);
    chk({15'h0000, interface_ready}, 16'h0001);
    rd(ADR_CHIP_CFG, 16'h0002);
    rd(ADR_ATTACH, 16'h0000);
  endtask

  // Far side stalled so the space count and lane handling can be seen
  task automatic t_write();
    logic [7:0] exp [9];
    exp = '{8'ha1, 8'hb2, 8'hc3, 8'he5, 8'h77, 8'h66, 8'h12, 8'h34, 8'hf0};
    bus(1'b1, ADR_ATTACH, 16'h0003, 2'b11);
    rd(ADR_ATTACH, 16'h0003);
    rd(ADR_WR_SPACE, 16'h0008);
    bus(1'b1, ADR_FIFO_WORD, 16'ha1b2, 2'b11);
    bus(1'b1, ADR_FIFO_WORD, 16'h00ff, 2'b01);
    bus(1'b1, ADR_FIFO_WORD, 16'hc300, 2'b10);
    bus(1'b1, ADR_FIFO_WORD, 16'h9900, 2'b10);
    bus(1'b1, ADR_FIFO_WORD, 16'hd4e5, 2'b11);
    rd(ADR_WR_SPACE, 16'h0004);
    bus(1'b1, ADR_BYTE_WR, 16'h0077, 2'b01);
    bus(1'b1, ADR_FIFO_WORD, 16'h0066, 2'b01);
    bus(1'b1, ADR_FIFO_WORD, 16'h1234, 2'b11);
    stall = 1'b0;
    @(negedge clock);
    stall = 1'b1;
    rd(ADR_WR_SPACE, 16'h0001);
    bus(1'b1, ADR_FIFO_WORD, 16'hf00f, 2'b11);
    rd(ADR_WR_SPACE, 16'h0000);
    // Direct RAM port takes data although the buffer is full
    bus(1'b1, ADR_RAM_PTR, 16'h0020, 2'b11);
    bus(1'b1, ADR_RAM_PORT, 16'habcd, 2'b11);
    chk(ram_write_data, 16'habcd);
    chk({14'h0000, ram_write_lanes}, 16'h0003);
    chk(16'(n_ram), 16'h0001);
    rd(ADR_RAM_PTR, 16'h0022);
    // Snapshot taken at one byte sent must survive eight more
    rd(ADR_STREAM_HI, 16'h0000);
    stall = 1'b0;
    repeat (20) @(negedge clock);
    rd(ADR_STREAM_LO, 16'h0001);
    chk(16'(u_far.got.size()), 16'h0009);
    foreach (exp[i]) chk({8'h00, u_far.got[i]}, {8'h00, exp[i]});
    rd(ADR_STREAM_HI, 16'h0000);
    rd(ADR_STREAM_LO, 16'h0009);
  endtask

  // Five bytes arrive; word and byte reads walk the boundary cases
  task automatic t_read();
    u_far.src = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    repeat (12) @(negedge clock);
    rd(ADR_RD_COUNT, 16'h8005);
    rd(ADR_FIFO_WORD, 16'h1122);
    rd(ADR_BYTE_RD, 16'h0033);
    rd(ADR_FIFO_WORD, 16'h0044);
    rd(ADR_FIFO_WORD, 16'h5500);
    // The odd read above leaves a boundary; detach must drop it
    u_far.src = '{8'h66, 8'h77, 8'h88};
    repeat (8) @(negedge clock);
    bus(1'b1, ADR_ATTACH, 16'h0001, 2'b11);
    rd(ADR_RD_COUNT, 16'h0000);
    bus(1'b1, ADR_ATTACH, 16'h0003, 2'b11);
    rd(ADR_RD_COUNT, 16'h8003);
    rd(ADR_FIFO_WORD, 16'h6677);
    rd(ADR_BYTE_RD, 16'h0088);
  endtask

  // Mid-run reset, then byte-enable mode, little-endian, and a freeze
  task automatic t_be_mode();
    stall = 1'b1;
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    chk({15'h0000, interface_ready}, 16'h0000);
    bus(1'b1, ADR_CHIP_CFG, 16'h5a01, 2'b01);
    bus(1'b1, ADR_CHIP_CFG, 16'h5a01, 2'b01);
    rd(ADR_CHIP_CFG, 16'h0001);
    bus(1'b1, ADR_ATTACH, 16'h0001, 2'b01);
    {upper_byte_enable_n, lower_byte_enable_n} = 2'b00;
    bus(1'b1, ADR_FIFO_WORD, 16'h3456, 2'b01);
    rd(ADR_WR_SPACE, 16'h0006);
    bus(1'b1, ADR_AREA_CLR, 16'h0000, 2'b01);
    rd(ADR_WR_SPACE, 16'h0008);
    bus(1'b1, ADR_FIFO_WORD, 16'hbcde, 2'b01);
    // Nothing may leave while the clock enable is low
    clock_en = 1'b0;
    stall = 1'b0;
    repeat (5) @(negedge clock);
    chk(16'(u_far.got.size()), 16'h0009);
    clock_en = 1'b1;
    repeat (5) @(negedge clock);
    chk(16'(u_far.got.size()), 16'h000b);
    chk({8'h00, u_far.got[9]}, 16'h00de);
    chk({8'h00, u_far.got[10]}, 16'h00bc);
  endtask

  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    low_byte_write_strobe_n = 1'b1;
    high_byte_write_strobe_n = 1'b1;
    address = 8'h00;
    data_in = 16'h0000;
    stall = 1'b1;
    clock_en = 1'b1;
    upper_byte_enable_n = 1'b1;
    lower_byte_enable_n = 1'b1;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    t_refuse();
    t_setup();
    t_write();
    t_read();
    t_be_mode();
    final_report();
  end
endmodule
